// file: design/dpll_mode_pkg.sv
// package: constants, types and decoders for the dpll mode controller
package dpll_mode_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_HOLD_WORD = 8'h0C;
    localparam int CTRL_OP_STATE_PICK_LSB = 0;
    localparam int CTRL_OP_STATE_PICK_MSB = 1;
    localparam int CTRL_REF_PICK = 2;
    localparam int CTRL_PHASE_STEP_HIDE_ENABLE = 3;
    localparam int CTRL_QUICK_ACQUIRE_REQUEST = 4;
    localparam int CTRL_REF_A_RATE_PICK_LSB = 5;
    localparam int CTRL_REF_A_RATE_PICK_MSB = 6;
    localparam int CTRL_REF_B_RATE_PICK_LSB = 7;
    localparam int CTRL_REF_B_RATE_PICK_MSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;
    localparam int CMD_SOFT_RESET = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_STATE_MSB = 2;
    localparam int STAT_NORMAL = 3;
    localparam int STAT_HOLDOVER = 4;
    localparam int STAT_FREERUN = 5;
    localparam int STAT_TIE = 6;
    localparam int STAT_REF_OK = 7;
    localparam int STAT_REF_ACT = 8;
    localparam int STAT_LOCK_LATE = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_FREERUN = 3'b000,
        ST_NORMAL = 3'b001,
        ST_AUTO_HOLD = 3'b010,
        ST_HOLDOVER = 3'b011,
        ST_SHORT_HOLD = 3'b100
    } op_state_e;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HOLDOVER = 2'h1;
    localparam logic [1:0] MODE_FREERUN = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam logic [1:0] RATE_19M44 = 2'h0;
    localparam logic [1:0] RATE_8K = 2'h1;
    localparam logic [1:0] RATE_1M544 = 2'h2;
    localparam logic [1:0] RATE_2M048 = 2'h3;

    localparam int CLK_PERIOD_PS = 10000;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int SAVE_PERIOD_MS = 30;
    localparam int SAVE_FRAMES = SAVE_PERIOD_MS * 1000000 / FRAME_PERIOD_NS;
    localparam int QUICK_LOCK_MS = 500;
    localparam int QUICK_LOCK_FRAMES = QUICK_LOCK_MS * 1000000 / FRAME_PERIOD_NS;
    localparam int LOCK_WAIT_S = 30;
    localparam int LOCK_WAIT_FRAMES = LOCK_WAIT_S * (1000000000 / FRAME_PERIOD_NS);
    localparam int REF_PS_19M44 = 51440;
    localparam int REF_PS_8K = 125000000;
    localparam int REF_PS_1M544 = 647668;
    localparam int REF_PS_2M048 = 488281;
    localparam int CAPTURE_DIV = 4;

    // nominal reference period in system clock cycles
    function automatic logic [15:0] nom_cycles(input logic [1:0] rate);
        case (rate)
            RATE_19M44: return 16'(REF_PS_19M44 / CLK_PERIOD_PS);
            RATE_8K: return 16'(REF_PS_8K / CLK_PERIOD_PS);
            RATE_1M544: return 16'(REF_PS_1M544 / CLK_PERIOD_PS);
            default: return 16'(REF_PS_2M048 / CLK_PERIOD_PS);
        endcase
    endfunction : nom_cycles
endpackage : dpll_mode_pkg

// file: design/ref_edge_if.sv
// interface: reference rates and pick in, qualified routed edge out
`timescale 1ns/1ps
interface ref_edge_if;
    logic [1:0] rate_a;
    logic [1:0] rate_b;
    logic pick;
    logic edge_sel;
    logic level_sel;
    modport qual (input rate_a, input rate_b, input pick, output edge_sel, output level_sel);
    modport ctl (output rate_a, output rate_b, output pick, input edge_sel, input level_sel);
endinterface : ref_edge_if

// file: design/ref_edge_qualifier.sv
// reference synchroniser, active-edge qualifier and routing mux
`timescale 1ns/1ps
module ref_edge_qualifier (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ref_input_a,
    input wire logic ref_input_b,
    ref_edge_if.qual bus
);
    import dpll_mode_pkg::*;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic edge_sel;
        logic level_sel;
    } qual_s;

    qual_s st_ff;
    qual_s nxt_st;
    logic [1:0] ev;
    logic [1:0] rate_of [2];

    // rising edge for the fastest rate, falling edge for the others
    function automatic logic edge_pick(input logic [1:0] rate, input logic now, input logic was);
        return (rate == RATE_19M44) ? (now & ~was) : (~now & was);
    endfunction : edge_pick

    assign rate_of[0] = bus.rate_a;
    assign rate_of[1] = bus.rate_b;

    for (genvar i = 0; i < 2; i++) begin : g_edge
        assign ev[i] = edge_pick(rate_of[i], st_ff.s2[i], st_ff.s3[i]);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {ref_input_b, ref_input_a};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.edge_sel = bus.pick ? ev[1] : ev[0];
        nxt_st.level_sel = bus.pick ? st_ff.s2[1] : st_ff.s2[0];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.edge_sel = st_ff.edge_sel;
    assign bus.level_sel = st_ff.level_sel;
endmodule : ref_edge_qualifier

// file: design/dpll_mode_state_control.sv
// operating-mode state controller with axi4-lite registers
// Contract
// - state changes happen only on a frame pulse rising edge; a soft reset also forces freerun at once, off the frame edge
// - mode pair 00 normal, 01 holdover, 10 freerun, 11 reserved
// - normal with invalid reference goes to auto-holdover by itself
// - auto-holdover returns to normal when reference valid, no select change
// - select change in auto-holdover goes to short holdover, correction off
// - select change in normal goes to short holdover, correction off
// - short holdover with steady select switches reference, returns normal
// - every change disables correction except entering normal from holds
// - normal, holdover, freerun status high in own mode only
// - lock within 30 s after reset in normal
// - quick acquire request selects fast lock, under 500 ms
// - locked normal saves frequency word every 30 ms in two slots
// - holdover entry uses the older saved word, 30 to 60 ms old; hold_word loads only on leaving normal, other entries keep it
// - holdover frequency stays within 0.025 ppm of saved word
// - freerun uses master oscillator only, references ignored
// - per-reference rate pair 00 19.44M, 01 8k, 10 1.544M, 11 2.048M
// - rate changes take effect only after a reset
// - falling edge for slow rates, rising edge for 19.44 MHz
// - reference pick 0 chooses input a, 1 chooses input b
// - chosen reference goes to correction, monitor and invalid detector
// - freerun and holdover keep phase compare and limiter inactive
// - reference invalid when outside capture range or lost
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module dpll_mode_state_control #(
    parameter int LOCK_WAIT_LIMIT = dpll_mode_pkg::LOCK_WAIT_FRAMES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [dpll_mode_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [dpll_mode_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic frame_pulse_8k_out,
    input wire logic ref_input_a,
    input wire logic ref_input_b,
    input wire logic dpll_locked,
    input wire logic [31:0] dco_freq_word,
    output logic normal_status,
    output logic holdover_status,
    output logic freerun_status,
    output logic phase_step_hide_active,
    output logic phase_compare_enable,
    output logic limiter_bypass,
    output logic ref_routed,
    output logic ref_routed_edge,
    output logic [31:0] hold_word
);
    import dpll_mode_pkg::*;

    typedef struct packed {
        op_state_e state;
        logic [2:0] stat;
        logic cmp_en;
        logic fast;
        logic [31:0] ctrl;
        logic [1:0] rate_a;
        logic [1:0] rate_b;
        logic fp_s1;
        logic fp_s2;
        logic fp_s3;
        logic sel_seen;
        logic ref_act;
        logic tie_on;
        logic [15:0] per_cnt;
        logic ref_ok;
        logic [7:0] save_cnt;
        logic slot_wr;
        logic [31:0] slot0;
        logic [31:0] slot1;
        logic [31:0] hold_word;
        logic [17:0] lock_cnt;
        logic lock_late;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic soft_rst;
    } ctl_s;

    ctl_s st_ff;
    ctl_s nxt_st;
    ref_edge_if bus ();
    op_state_e step_state;
    logic fp_rise;
    logic sel_pick;
    logic sel_change;
    logic [1:0] mode;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic [31:0] older_slot;
    logic [31:0] status_word;

    ref_edge_qualifier u_qual (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ref_input_a(ref_input_a),
        .ref_input_b(ref_input_b),
        .bus(bus)
    );

    // reserved code holds the current state; manual codes win over automatic moves
    function automatic op_state_e next_state(input op_state_e st, input logic [1:0] md,
                                             input logic chg, input logic ok);
        op_state_e ns;
        ns = st;
        case (md)
            MODE_HOLDOVER: ns = ST_HOLDOVER;
            MODE_FREERUN: ns = ST_FREERUN;
            MODE_NORMAL: begin
                case (st)
                    ST_FREERUN, ST_HOLDOVER: ns = ST_NORMAL;
                    ST_NORMAL: ns = chg ? ST_SHORT_HOLD : (!ok ? ST_AUTO_HOLD : st);
                    ST_AUTO_HOLD: ns = chg ? ST_SHORT_HOLD : (ok ? ST_NORMAL : st);
                    ST_SHORT_HOLD: ns = chg ? ST_SHORT_HOLD : ST_NORMAL;
                    default: ns = ST_FREERUN;
                endcase
            end
            default: ns = st;
        endcase
        return ns;
    endfunction : next_state

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r & CTRL_MASK;
    endfunction : apply_strb

    function automatic logic [2:0] status_of(input op_state_e st);
        return {st == ST_FREERUN, st == ST_HOLDOVER, st == ST_NORMAL};
    endfunction : status_of

    assign fp_rise = st_ff.fp_s2 & ~st_ff.fp_s3;
    assign sel_pick = st_ff.ctrl[CTRL_REF_PICK];
    assign sel_change = sel_pick != st_ff.sel_seen;
    assign mode = st_ff.ctrl[CTRL_OP_STATE_PICK_MSB:CTRL_OP_STATE_PICK_LSB];
    assign step_state = next_state(st_ff.state, mode, sel_change, st_ff.ref_ok);
    assign older_slot = st_ff.slot_wr ? st_ff.slot1 : st_ff.slot0;
    // capture window of nominal period +- a quarter, plus one cycle of sampling slack
    assign win_lo = nom_cycles(bus.pick ? st_ff.rate_b : st_ff.rate_a)
        - (nom_cycles(bus.pick ? st_ff.rate_b : st_ff.rate_a) / 16'(CAPTURE_DIV)) - 16'h1;
    assign win_hi = nom_cycles(bus.pick ? st_ff.rate_b : st_ff.rate_a)
        + (nom_cycles(bus.pick ? st_ff.rate_b : st_ff.rate_a) / 16'(CAPTURE_DIV)) + 16'h1;

    assign bus.rate_a = st_ff.rate_a;
    assign bus.rate_b = st_ff.rate_b;
    assign bus.pick = st_ff.ref_act;

    always_comb begin
        status_word = '0;
        status_word[STAT_STATE_MSB:STAT_STATE_LSB] = st_ff.state;
        status_word[STAT_NORMAL] = st_ff.stat[0];
        status_word[STAT_HOLDOVER] = st_ff.stat[1];
        status_word[STAT_FREERUN] = st_ff.stat[2];
        status_word[STAT_TIE] = st_ff.tie_on;
        status_word[STAT_REF_OK] = st_ff.ref_ok;
        status_word[STAT_REF_ACT] = st_ff.ref_act;
        status_word[STAT_LOCK_LATE] = st_ff.lock_late;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.fp_s1 = frame_pulse_8k_out;
        nxt_st.fp_s2 = st_ff.fp_s1;
        nxt_st.fp_s3 = st_ff.fp_s2;
        nxt_st.soft_rst = 1'b0;
        // write address and data are caught independently, committed together
        if (awvalid && !st_ff.aw_held) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (wvalid && !st_ff.w_held) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = wdata;
            nxt_st.wstrb = wstrb;
        end
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            case (st_ff.aw_addr)
                OFS_CTRL: nxt_st.ctrl = apply_strb(st_ff.ctrl, st_ff.wdata, st_ff.wstrb);
                OFS_CMD: nxt_st.soft_rst = st_ff.wstrb[0] & st_ff.wdata[CMD_SOFT_RESET];
                OFS_STATUS, OFS_HOLD_WORD: nxt_st.bresp = RESP_OKAY;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            case (araddr)
                OFS_CTRL: nxt_st.rdata = st_ff.ctrl;
                OFS_CMD: nxt_st.rdata = '0;
                OFS_STATUS: nxt_st.rdata = status_word;
                OFS_HOLD_WORD: nxt_st.rdata = st_ff.hold_word;
                default: begin
                    nxt_st.rdata = '0;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        // invalid-reference detector on the routed reference
        if (bus.edge_sel) begin
            nxt_st.per_cnt = '0;
            nxt_st.ref_ok = (st_ff.per_cnt >= win_lo) && (st_ff.per_cnt <= win_hi);
        end else if (st_ff.per_cnt > win_hi) begin
            nxt_st.ref_ok = 1'b0;
        end else begin
            nxt_st.per_cnt = st_ff.per_cnt + 16'h1;
        end
        if (fp_rise) begin
            nxt_st.sel_seen = sel_pick;
            if (step_state != st_ff.state) begin
                nxt_st.state = step_state;
                nxt_st.tie_on = 1'b0;
                if (step_state == ST_NORMAL) begin
                    nxt_st.ref_act = sel_pick;
                    if (st_ff.state != ST_FREERUN) begin
                        nxt_st.tie_on = st_ff.ctrl[CTRL_PHASE_STEP_HIDE_ENABLE];
                    end
                end
                if (st_ff.state == ST_NORMAL &&
                    (step_state == ST_HOLDOVER || step_state == ST_AUTO_HOLD)) begin
                    nxt_st.hold_word = older_slot;
                end
                nxt_st.save_cnt = '0;
                nxt_st.lock_cnt = '0;
                nxt_st.lock_late = 1'b0;
            end else if (st_ff.state == ST_NORMAL) begin
                if (dpll_locked) begin
                    nxt_st.lock_cnt = '0;
                    nxt_st.save_cnt = st_ff.save_cnt + 8'h1;
                    if (st_ff.save_cnt == 8'(SAVE_FRAMES - 1)) begin
                        nxt_st.save_cnt = '0;
                        nxt_st.slot_wr = ~st_ff.slot_wr;
                        if (st_ff.slot_wr) begin
                            nxt_st.slot1 = dco_freq_word;
                        end else begin
                            nxt_st.slot0 = dco_freq_word;
                        end
                    end
                end else if (!st_ff.lock_late) begin
                    nxt_st.lock_cnt = st_ff.lock_cnt + 18'h1;
                    if (st_ff.fast ? (st_ff.lock_cnt >= 18'(QUICK_LOCK_FRAMES - 1))
                                   : (st_ff.lock_cnt >= 18'(LOCK_WAIT_LIMIT - 1))) begin
                        nxt_st.lock_late = 1'b1;
                    end
                end
            end
        end
        // soft reset restarts the controller and is the only way new rates load
        if (st_ff.soft_rst) begin
            nxt_st.state = ST_FREERUN;
            nxt_st.rate_a = st_ff.ctrl[CTRL_REF_A_RATE_PICK_MSB:CTRL_REF_A_RATE_PICK_LSB];
            nxt_st.rate_b = st_ff.ctrl[CTRL_REF_B_RATE_PICK_MSB:CTRL_REF_B_RATE_PICK_LSB];
            nxt_st.tie_on = 1'b0;
            nxt_st.ref_ok = 1'b0;
            nxt_st.per_cnt = '0;
            nxt_st.save_cnt = '0;
            nxt_st.lock_cnt = '0;
            nxt_st.lock_late = 1'b0;
        end
        nxt_st.stat = status_of(nxt_st.state);
        nxt_st.cmp_en = nxt_st.state == ST_NORMAL;
        nxt_st.fast = (nxt_st.state == ST_NORMAL)
            & nxt_st.ctrl[CTRL_QUICK_ACQUIRE_REQUEST];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.state <= ST_FREERUN;
            st_ff.stat <= 3'h4;
            st_ff.ctrl <= CTRL_RESET;
            st_ff.rate_a <= RATE_19M44;
            st_ff.rate_b <= RATE_19M44;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign awready = !st_ff.aw_held;
    assign wready = !st_ff.w_held;
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign arready = !st_ff.rvalid;
    assign rvalid = st_ff.rvalid;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;
    assign normal_status = st_ff.stat[0];
    assign holdover_status = st_ff.stat[1];
    assign freerun_status = st_ff.stat[2];
    assign phase_step_hide_active = st_ff.tie_on;
    assign phase_compare_enable = st_ff.cmp_en;
    assign limiter_bypass = st_ff.fast;
    assign ref_routed = bus.level_sel;
    assign ref_routed_edge = bus.edge_sel;
    assign hold_word = st_ff.hold_word;

    property p_state_on_frame;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_ff.state != $past(st_ff.state)) |-> ($past(fp_rise) || $past(st_ff.soft_rst));
    endproperty
    a_state_on_frame: assert property (p_state_on_frame) else $error("state moved off frame edge");

    property p_freerun_code;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && mode == MODE_FREERUN) |=> (st_ff.state == ST_FREERUN && freerun_status);
    endproperty
    a_freerun_code: assert property (p_freerun_code) else $error("freerun code not obeyed");

    property p_reserved_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && mode == MODE_RESERVED && !st_ff.soft_rst) |=> $stable(st_ff.state);
    endproperty
    a_reserved_hold: assert property (p_reserved_hold) else $error("reserved code moved state");

    property p_auto_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && st_ff.state == ST_NORMAL && mode == MODE_NORMAL && !sel_change
         && !st_ff.ref_ok && !st_ff.soft_rst) |=> (st_ff.state == ST_AUTO_HOLD && !st_ff.tie_on);
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("no auto holdover on bad ref");

    property p_sel_to_short;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && mode == MODE_NORMAL && sel_change && !st_ff.soft_rst
         && (st_ff.state == ST_NORMAL || st_ff.state == ST_AUTO_HOLD))
        |=> (st_ff.state == ST_SHORT_HOLD && !phase_step_hide_active);
    endproperty
    a_sel_to_short: assert property (p_sel_to_short) else $error("select change missed");

    property p_short_return;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && st_ff.state == ST_SHORT_HOLD && mode == MODE_NORMAL && !sel_change
         && !st_ff.soft_rst) |=> (st_ff.state == ST_NORMAL && st_ff.ref_act == $past(sel_pick)
         && st_ff.tie_on == $past(st_ff.ctrl[CTRL_PHASE_STEP_HIDE_ENABLE]));
    endproperty
    a_short_return: assert property (p_short_return) else $error("short holdover exit wrong");

    property p_tie_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_ff.state != $past(st_ff.state) && st_ff.state != ST_NORMAL) |-> !st_ff.tie_on;
    endproperty
    a_tie_off: assert property (p_tie_off) else $error("correction left on after change");

    property p_status;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 (normal_status == (st_ff.state == ST_NORMAL))
            && (holdover_status == (st_ff.state == ST_HOLDOVER))
            && (phase_compare_enable == normal_status);
    endproperty
    a_status: assert property (p_status) else $error("status outputs disagree");

    property p_hold_word;
        @(posedge clk_sys) disable iff (!rst_n)
        (fp_rise && st_ff.state == ST_NORMAL && mode == MODE_HOLDOVER && !st_ff.soft_rst)
        |=> (holdover_status && hold_word == $past(older_slot));
    endproperty
    a_hold_word: assert property (p_hold_word) else $error("holdover word not older slot");
endmodule : dpll_mode_state_control

// file: sim/ref_source_model.sv
// far-side model: frame pulse pin and two reference clocks
`timescale 1ns/1ps
module ref_source_model #(
    parameter int FRAME_CYC = 100
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic frame_pulse_8k_out,
    output logic ref_input_a,
    output logic ref_input_b
);
    int cnt;
    int ph;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            ph <= 0;
        end else begin
            cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
            ph <= (ph == 5) ? 0 : ph + 1;
        end
    end
    assign frame_pulse_8k_out = (cnt < 10);
    // six-cycle period sits inside the capture window; run low means loss
    assign ref_input_a = run && (ph < 3);
    assign ref_input_b = run && (ph >= 3);
endmodule : ref_source_model

// file: sim/dpll_mode_state_control_tb_top.sv
// testbench for the dpll mode state controller
`timescale 1ns/1ps
module dpll_mode_state_control_tb_top;
    import dpll_mode_pkg::*;
    logic clk_sys = 1'h0, rst_n = 1'h0, run = 1'h1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, hold_word, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, frame_pulse_8k_out, ref_input_a, ref_input_b;
    logic normal_status, holdover_status, freerun_status, phase_step_hide_active;
    logic phase_compare_enable;
    logic locked = 1'h1, bypass, routed, redge;
    logic [31:0] word = 32'h1234_5678;
    int fails = 0, checks = 0;
    ref_source_model far (.clk_sys, .rst_n, .run, .frame_pulse_8k_out, .ref_input_a, .ref_input_b);
    dpll_mode_state_control #(.LOCK_WAIT_LIMIT(8)) dut (.clk_sys, .rst_n, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .frame_pulse_8k_out, .ref_input_a,
        .ref_input_b, .dpll_locked(locked), .dco_freq_word(word), .normal_status,
        .holdover_status, .freerun_status, .phase_step_hide_active, .phase_compare_enable,
        .limiter_bypass(bypass), .ref_routed(routed), .ref_routed_edge(redge), .hold_word);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd
    task automatic fr(input int n);
        repeat (n) @(posedge frame_pulse_8k_out);
        repeat (8) @(posedge clk_sys);
    endtask : fr
    task automatic st(input logic [2:0] e);
        rd(OFS_STATUS);
        chk("state", {29'h0, e}, d & 32'h7);
    endtask : st
    task automatic t_reset();
        chk("freerun", 1'h1, freerun_status);
        chk("normal", 1'h0, normal_status);
        rd(OFS_CTRL);
        chk("ctrl", CTRL_RESET, d);
    endtask : t_reset
    task automatic t_switch();
        wr(OFS_CTRL, 32'h8);
        fr(2);
        chk("normal", 1'h1, normal_status);
        chk("tie", 1'h0, phase_step_hide_active);
        chk("compare", 1'h1, phase_compare_enable);
        wr(OFS_CTRL, 32'hC);
        fr(1);
        st(ST_SHORT_HOLD);
        chk("tie", 1'h0, phase_step_hide_active);
        fr(1);
        chk("normal", 1'h1, normal_status);
        chk("tie", 1'h1, phase_step_hide_active);
    endtask : t_switch
    task automatic t_auto();
        int n = 0;
        @(posedge clk_sys);
        run <= 1'h0;
        fr(2);
        st(ST_AUTO_HOLD);
        chk("normal", 1'h0, normal_status);
        chk("routed", 1'h0, routed);
        run <= 1'h1;
        fr(2);
        chk("normal", 1'h1, normal_status);
        chk("tie", 1'h1, phase_step_hide_active);
        repeat (60) begin
            @(posedge clk_sys);
            n += int'(redge);
        end
        chk("edges", 32'hA, n);
    endtask : t_auto
    task automatic t_save();
        locked <= 1'h0;
        fr(9);
        rd(OFS_STATUS);
        chk("lock_late", 1'h1, d[STAT_LOCK_LATE]);
        locked <= 1'h1;
        wr(OFS_CTRL, 32'h1C);
        chk("bypass", 1'h1, bypass);
        fr(300);
        word <= 32'h0000_5A5A;
        fr(200);
    endtask : t_save
    task automatic t_modes();
        wr(OFS_CTRL, 32'h9);
        fr(2);
        chk("holdover", 1'h1, holdover_status);
        chk("hold_word", 32'h1234_5678, hold_word);
        chk("bypass", 1'h0, bypass);
        chk("tie", 1'h0, phase_step_hide_active);
        chk("compare", 1'h0, phase_compare_enable);
        wr(OFS_CTRL, 32'hB);
        fr(2);
        st(ST_HOLDOVER);
        wr(OFS_CTRL, 32'hA);
        fr(2);
        chk("freerun", 1'h1, freerun_status);
        wr(OFS_CTRL, 32'h8A);
        repeat (20) @(posedge clk_sys);
        rd(OFS_STATUS);
        chk("ref_ok", 1'h1, d[STAT_REF_OK]);
        wr(OFS_CMD, 32'h1);
        repeat (20) @(posedge clk_sys);
        rd(OFS_STATUS);
        chk("ref_ok", 1'h0, d[STAT_REF_OK]);
        rd(8'h10);
        chk("rresp", RESP_SLVERR, r);
    endtask : t_modes
    task automatic wrap_up();
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #800000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_reset();
        t_switch();
        t_auto();
        t_save();
        t_modes();
        wrap_up();
    end
endmodule : dpll_mode_state_control_tb_top
